//--- rtl/ctrl_dac_defs.vh
// constants for the chip control, margin dac and spread spectrum register bank
`ifndef CTRL_DAC_DEFS_VH
`define CTRL_DAC_DEFS_VH

// register port widths
`define ADDR_W 8
`define DATA_W 8

// register addresses on the serial register port
`define ADDR_CHIP_CTRL 8'h00
`define ADDR_LOW_DAC 8'h01
`define ADDR_HIGH_DAC 8'h02
`define ADDR_SET_DAC 8'h03
`define ADDR_SPREAD 8'h04

// chip control bit positions
`define BIT_WP 0
`define BIT_SOFT_RST 1
`define BIT_COMM_FAULT 2

// implemented-bit masks, reserved bits read zero
`define MASK_MARGIN 8'h7f
`define MASK_SET 8'h1f
`define MASK_SPREAD 8'h1f

// default value of every read/write register
`define RST_VAL 8'h00
// the same default cut to each stored field width
`define RST_MARGIN 7'h00
`define RST_SET 5'h00
`define RST_SPREAD 5'h00
// set pin current after reset: the 16 microamp base alone
`define RST_SET_PIN 5'h10

// field positions
`define MARGIN_SIGN 6
`define SET_HALF_BIT 4
`define SPREAD_RANGE_HI 4
`define SPREAD_RANGE_LO 3
`define SPREAD_RATE_HI 2
`define SPREAD_RATE_LO 0

// spread range codes and percent values
`define RANGE_12 2'h0
`define RANGE_15 2'h1
`define RANGE_10 2'h2
`define PCT_12 4'hc
`define PCT_15 4'hf
`define PCT_10 4'ha
`define PCT_8 4'h8

// modulation rate codes and log2 of the divider
`define RATE_512 3'h0
`define RATE_1024 3'h1
`define RATE_2048 3'h2
`define RATE_4096 3'h3
`define RATE_256 3'h4
`define RATE_128 3'h5
`define RATE_64 3'h6
`define LOG2_512 4'h9
`define LOG2_1024 4'ha
`define LOG2_2048 4'hb
`define LOG2_4096 4'hc
`define LOG2_256 4'h8
`define LOG2_128 4'h7
`define LOG2_64 4'h6

`endif

//--- rtl/margin_dac_apply.v
// margin dac stage: passes a signed code to its feedback node in one mode only
`timescale 1ns/1ps
`include "ctrl_dac_defs.vh"

module margin_dac_apply (
	// clock and reset
	input wire clk_in,
	input wire srst_in,
	// code and mode
	input wire [6:0] code_in,
	input wire mode_active_in,
	// applied current
	output reg [6:0] ua_out,
	output reg sink_out
);

	////////////////////////////////////////////////////////////////////////////
	// register applied code, zero current outside the active mode
	always @(posedge clk_in) begin
		if (srst_in) begin
			ua_out <= `RST_MARGIN;
			sink_out <= 1'b0;
		end else if (mode_active_in) begin
			// mode gated current
			ua_out <= code_in;
			sink_out <= code_in[`MARGIN_SIGN];
		end else begin
			// inactive mode, no current
			ua_out <= `RST_MARGIN;
			sink_out <= 1'b0;
		end
	end

endmodule

//--- rtl/spread_decode.v
// spread spectrum field decoder: range percent and modulation divider
`timescale 1ns/1ps
`include "ctrl_dac_defs.vh"

module spread_decode (
	// clock and reset
	input wire clk_in,
	input wire srst_in,
	// register fields
	input wire [1:0] range_in,
	input wire [2:0] rate_in,
	// decoded settings
	output reg [3:0] range_pct_out,
	output reg [3:0] div_log2_out
);

	////////////////////////////////////////////////////////////////////////////
	// decode both fields into registered settings
	always @(posedge clk_in) begin
		if (srst_in) begin
			range_pct_out <= `PCT_12;
			div_log2_out <= `LOG2_512;
		end else begin
			case (range_in)
				`RANGE_12: range_pct_out <= `PCT_12;
				`RANGE_15: range_pct_out <= `PCT_15;
				`RANGE_10: range_pct_out <= `PCT_10;
				default: range_pct_out <= `PCT_8;
			endcase
			case (rate_in)
				`RATE_1024: div_log2_out <= `LOG2_1024;
				`RATE_2048: div_log2_out <= `LOG2_2048;
				`RATE_4096: div_log2_out <= `LOG2_4096;
				`RATE_256: div_log2_out <= `LOG2_256;
				`RATE_128: div_log2_out <= `LOG2_128;
				`RATE_64: div_log2_out <= `LOG2_64;
				default: div_log2_out <= `LOG2_512;
			endcase
		end
	end

endmodule

//--- rtl/control_dac_margin_regs.v
// chip control, margin dac, current-set dac and spread spectrum register bank
`timescale 1ns/1ps
`include "ctrl_dac_defs.vh"

module control_dac_margin_regs (
	// clock and reset
	input wire clk_in,
	input wire srst_in,
	// register port from the serial frame logic
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [`ADDR_W-1:0] reg_addr_in,
	input wire [`DATA_W-1:0] reg_wdata_in,
	input wire pec_ok_in,
	// register port answers
	output reg [`DATA_W-1:0] reg_rdata_out,
	output reg reg_rvalid_out,
	output reg reg_wack_out,
	output reg reg_wrefused_out,
	// operating mode pin, high in buck, low in boost
	input wire buck_mode_in,
	// chip control state
	output reg comm_fault_flag_out,
	output reg write_protect_out,
	output reg soft_reset_busy_out,
	// low side feedback margin current
	output wire [6:0] low_side_feedback_ua_out,
	output wire low_side_sink_out,
	// high side feedback margin current
	output wire [6:0] high_side_feedback_ua_out,
	output wire high_side_sink_out,
	// current set pin sourcing current
	output reg [4:0] current_set_pin_ua_out,
	// spread spectrum settings
	output wire [3:0] spread_range_pct_out,
	output wire [3:0] mod_div_log2_out
);

	////////////////////////////////////////////////////////////////////////////
	// storage

	// write protect bit of chip control
	reg wp_r;
	// self-clearing reset bit, high while the restore is pending
	reg rst_busy_r;
	// communication fault flag
	reg fault_r;
	// low side margin code
	reg [6:0] low_dac_r;
	// high side margin code
	reg [6:0] high_dac_r;
	// current set code
	reg [4:0] set_dac_r;
	// spread spectrum range and rate
	reg [4:0] spread_r;
	// mode pin synchroniser
	reg buck_meta_r;
	reg buck_mode_r;

	////////////////////////////////////////////////////////////////////////////
	// address decode and write qualification

	// address hits
	wire hit_chip;
	wire hit_low;
	wire hit_high;
	wire hit_set;
	wire hit_spread;
	// any mapped address
	wire hit_any;
	// protected register addressed
	wire hit_guarded;
	// write that passed or failed the error-code check
	wire wr_good;
	wire wr_bad;
	// write that really lands in a register
	wire wr_take;

	assign hit_chip = (reg_addr_in == `ADDR_CHIP_CTRL);
	assign hit_low = (reg_addr_in == `ADDR_LOW_DAC);
	assign hit_high = (reg_addr_in == `ADDR_HIGH_DAC);
	assign hit_set = (reg_addr_in == `ADDR_SET_DAC);
	assign hit_spread = (reg_addr_in == `ADDR_SPREAD);
	assign hit_any = hit_chip | hit_low | hit_high | hit_set | hit_spread;
	assign hit_guarded = hit_low | hit_high | hit_set | hit_spread;

	assign wr_good = reg_wr_in & pec_ok_in;
	assign wr_bad = reg_wr_in & ~pec_ok_in;

	assign wr_take = wr_good & hit_any & ~rst_busy_r & ~(hit_guarded & wp_r);

	////////////////////////////////////////////////////////////////////////////
	// mode pin synchroniser, the pin is asynchronous to clk_in

	always @(posedge clk_in) begin
		if (srst_in) begin
			buck_meta_r <= 1'b0;
			buck_mode_r <= 1'b0;
		end else begin
			// two stage capture
			buck_meta_r <= buck_mode_in;
			buck_mode_r <= buck_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chip control: write protect and self-clearing reset

	always @(posedge clk_in) begin
		if (srst_in) begin
			wp_r <= 1'b0;
			rst_busy_r <= 1'b0;
		end else if (rst_busy_r) begin
			wp_r <= 1'b0;
			rst_busy_r <= 1'b0;
		end else if (wr_take && hit_chip) begin
			wp_r <= reg_wdata_in[`BIT_WP];
			rst_busy_r <= reg_wdata_in[`BIT_SOFT_RST];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// communication fault flag, a new fault wins over a clear

	always @(posedge clk_in) begin
		if (srst_in) begin
			fault_r <= 1'b0;
		end else if (wr_bad) begin
			fault_r <= 1'b1;
		end else if (wr_take && hit_chip && reg_wdata_in[`BIT_COMM_FAULT]) begin
			fault_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// dac and spread spectrum registers

	always @(posedge clk_in) begin
		if (srst_in || rst_busy_r) begin
			low_dac_r <= `RST_MARGIN;
			high_dac_r <= `RST_MARGIN;
			set_dac_r <= `RST_SET;
			spread_r <= `RST_SPREAD;
		end else if (wr_take) begin
			if (hit_low) begin
				low_dac_r <= reg_wdata_in[6:0];
			end
			if (hit_high) begin
				high_dac_r <= reg_wdata_in[6:0];
			end
			if (hit_set) begin
				set_dac_r <= reg_wdata_in[4:0];
			end
			// range and rate fields
			if (hit_spread) begin
				spread_r <= reg_wdata_in[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read back, one cycle after the request

	// read value of the addressed register
	reg [`DATA_W-1:0] rd_mux;

	always @* begin
		rd_mux = `RST_VAL;
		if (hit_chip) begin
			rd_mux[`BIT_WP] = wp_r;
			rd_mux[`BIT_SOFT_RST] = rst_busy_r;
			rd_mux[`BIT_COMM_FAULT] = fault_r;
		end else if (hit_low) begin
			rd_mux = {1'b0, low_dac_r} & `MASK_MARGIN;
		end else if (hit_high) begin
			rd_mux = {1'b0, high_dac_r} & `MASK_MARGIN;
		end else if (hit_set) begin
			rd_mux = {3'b000, set_dac_r} & `MASK_SET;
		end else if (hit_spread) begin
			rd_mux = {3'b000, spread_r} & `MASK_SPREAD;
		end
	end

	// read data and its strobe
	always @(posedge clk_in) begin
		if (srst_in) begin
			reg_rdata_out <= `RST_VAL;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				// unmapped addresses read zero
				reg_rdata_out <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write answers

	always @(posedge clk_in) begin
		if (srst_in) begin
			reg_wack_out <= 1'b0;
			reg_wrefused_out <= 1'b0;
		end else begin
			// accepted write
			reg_wack_out <= wr_take;
			// failed check, protected, busy or unmapped
			reg_wrefused_out <= reg_wr_in & ~wr_take;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// chip control state outputs

	always @(posedge clk_in) begin
		if (srst_in) begin
			comm_fault_flag_out <= 1'b0;
			write_protect_out <= 1'b0;
			soft_reset_busy_out <= 1'b0;
		end else begin
			// mirrors of the chip control bits
			comm_fault_flag_out <= fault_r;
			write_protect_out <= wp_r;
			soft_reset_busy_out <= rst_busy_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// current set pin: bit 4 clear keeps the 16 microamp base

	always @(posedge clk_in) begin
		if (srst_in) begin
			current_set_pin_ua_out <= `RST_SET_PIN;
		end else begin
			current_set_pin_ua_out <= {~set_dac_r[`SET_HALF_BIT], set_dac_r[3:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// margin dac stages

	margin_dac_apply u_low_dac (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.code_in(low_dac_r),
		.mode_active_in(buck_mode_r),
		.ua_out(low_side_feedback_ua_out),
		.sink_out(low_side_sink_out)
	);

	margin_dac_apply u_high_dac (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.code_in(high_dac_r),
		.mode_active_in(~buck_mode_r),
		.ua_out(high_side_feedback_ua_out),
		.sink_out(high_side_sink_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// spread spectrum decode

	spread_decode u_spread (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.range_in(spread_r[`SPREAD_RANGE_HI:`SPREAD_RANGE_LO]),
		.rate_in(spread_r[`SPREAD_RATE_HI:`SPREAD_RATE_LO]),
		.range_pct_out(spread_range_pct_out),
		.div_log2_out(mod_div_log2_out)
	);

endmodule

//--- verification/host_model.sv
// host model driving the register port of the bank
`timescale 1ns/1ps
module host_model (
	// clock
	input wire clk_in,
	// requests
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic pec_ok_out,
	// answers
	input wire [7:0] reg_rdata_in,
	input wire reg_wack_in,
	input wire reg_wrefused_in
);
	// idle port at time zero
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		pec_ok_out = 1'b0;
	end
	// one write, answer taken with the release
	task wr(input logic [7:0] a, input logic [7:0] d, input logic ok, output logic [1:0] ans);
		@(posedge clk_in);
		#1;
		reg_wr_out = 1'b1;
		reg_addr_out = a;
		reg_wdata_out = d;
		pec_ok_out = ok;
		@(posedge clk_in);
		#1;
		ans = {reg_wack_in, reg_wrefused_in};
		// released lines carry the inverse, never a stale value
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
		pec_ok_out = ~ok;
	endtask
	// one read
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		reg_rd_out = 1'b1;
		reg_addr_out = a;
		@(posedge clk_in);
		#1;
		d = reg_rdata_in;
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
	endtask
endmodule

//--- verification/ctrl_dac_checker.sv
// port assertions for the register bank
`timescale 1ns/1ps
`include "ctrl_dac_defs.vh"
module ctrl_dac_checker (
	// clock and reset
	input wire clk_in,
	input wire srst_in,
	// register port
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire pec_ok_in,
	input wire [7:0] reg_rdata_out,
	input wire reg_wack_out,
	input wire reg_wrefused_out,
	// mode and state
	input wire buck_mode_in,
	input wire comm_fault_flag_out,
	input wire write_protect_out,
	input wire soft_reset_busy_out,
	// applied currents
	input wire [6:0] low_side_feedback_ua_out,
	input wire [6:0] high_side_feedback_ua_out,
	input wire [4:0] current_set_pin_ua_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// good writes, fault clearing and bank addresses
	wire wr_ok = reg_wr_in && pec_ok_in;
	wire clr_req = wr_ok && reg_addr_in == `ADDR_CHIP_CTRL && reg_wdata_in[`BIT_COMM_FAULT];
	wire in_bank = reg_addr_in >= `ADDR_LOW_DAC && reg_addr_in <= `ADDR_SPREAD;
	// soft reset steps
	sequence sr_req;
		wr_ok && reg_addr_in == `ADDR_CHIP_CTRL && reg_wdata_in[`BIT_SOFT_RST]
			&& !soft_reset_busy_out;
	endsequence
	sequence sr_clear;
		!soft_reset_busy_out && !write_protect_out;
	endsequence
	// set pin current for a written code: 16 unless bit 4, plus bits 3:0
	wire [4:0] set_ua = (reg_wdata_in[4] ? 5'h00 : 5'h10) + {1'b0, reg_wdata_in[3:0]};
	property set_cur_p;
		(wr_ok && reg_addr_in == `ADDR_SET_DAC) ##1 reg_wack_out
			|=> current_set_pin_ua_out == $past(set_ua, 2);
	endproperty
	fault_set_a: assert property (reg_wr_in && !pec_ok_in
		|=> reg_wrefused_out ##1 comm_fault_flag_out) else $error("fault not raised");
	fault_clear_a: assert property ($fell(comm_fault_flag_out) |-> $past(clr_req, 2))
		else $error("fault cleared without a one");
	wp_block_a: assert property (write_protect_out && $past(write_protect_out)
		&& !$past(reg_wr_in) && !soft_reset_busy_out && reg_wr_in && in_bank
		|=> reg_wrefused_out) else $error("protected write taken");
	wr_answer_a: assert property (reg_wr_in |=> reg_wack_out != reg_wrefused_out)
		else $error("write not answered once");
	rsvd_zero_a: assert property (reg_rd_in && reg_addr_in >= 8'h03
		|=> reg_rdata_out[7:5] == 3'h0) else $error("reserved bits read high");
	set_cur_a: assert property (set_cur_p)
		else $error("current set value wrong");
	low_gate_a: assert property (!buck_mode_in [*4] |-> low_side_feedback_ua_out == 7'h00)
		else $error("low margin applied in boost");
	high_gate_a: assert property (buck_mode_in [*4] |-> high_side_feedback_ua_out == 7'h00)
		else $error("high margin applied in buck");
	soft_rst_a: assert property (sr_req |=> reg_wack_out ##[1:3] sr_clear
		##[0:3] current_set_pin_ua_out == 5'h10) else $error("soft reset incomplete");
endmodule
bind control_dac_margin_regs ctrl_dac_checker u_chk (.clk_in, .srst_in, .reg_wr_in,
	.reg_rd_in, .reg_addr_in, .reg_wdata_in, .pec_ok_in, .reg_rdata_out, .reg_wack_out,
	.reg_wrefused_out, .buck_mode_in, .comm_fault_flag_out, .write_protect_out,
	.soft_reset_busy_out, .low_side_feedback_ua_out, .high_side_feedback_ua_out,
	.current_set_pin_ua_out);

//--- verification/tb.sv
// testbench for the register bank
`timescale 1ns/1ps
module tb;
	// clock, reset and mode pin
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic buck_mode_in = 1'b1;
	// port wires
	wire wr, rd, pec, wack, wref, fault, lsink, hsink, rvld, wpo;
	wire [7:0] addr, wdata, rdata;
	wire [6:0] lua, hua;
	wire [4:0] cua;
	wire [3:0] pct, dlg;
	// counters and scratch
	int err_total = 0;
	int n_compared = 0;
	int i;
	logic [1:0] ans;
	logic [7:0] v;
	logic [7:0] cs [5] = '{8'h00, 8'h10, 8'h1f, 8'h0f, 8'he5};
	// set pin microamps expected for each code above
	logic [7:0] cx [5] = '{8'h10, 8'h00, 8'h0f, 8'h1f, 8'h15};
	always #2 clk_in = ~clk_in;
	control_dac_margin_regs u_dut (.clk_in, .srst_in, .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .pec_ok_in(pec), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvld), .reg_wack_out(wack), .reg_wrefused_out(wref), .buck_mode_in,
		.comm_fault_flag_out(fault), .write_protect_out(wpo), .soft_reset_busy_out(),
		.low_side_feedback_ua_out(lua), .low_side_sink_out(lsink),
		.high_side_feedback_ua_out(hua), .high_side_sink_out(hsink),
		.current_set_pin_ua_out(cua), .spread_range_pct_out(pct), .mod_div_log2_out(dlg));
	host_model u_host (.clk_in, .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .pec_ok_out(pec), .reg_rdata_in(rdata), .reg_wack_in(wack),
		.reg_wrefused_in(wref));
	// byte compare
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// write with expected {ack, refused}
	task w(input logic [7:0] a, input logic [7:0] d, input logic ok, input logic [1:0] e);
		u_host.wr(a, d, ok, ans);
		chk({6'h00, ans}, {6'h00, e});
	endtask
	task r(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, v);
		chk(v, e);
		// read strobe stands in the answer cycle
		chk({7'h00, rvld}, 8'h01);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// expected {percent, log2 divider} of a spread code
	function logic [7:0] spexp(input logic [4:0] c);
		logic [3:0] p;
		logic [3:0] d;
		case (c[4:3])
			2'h0: p = 4'hc;
			2'h1: p = 4'hf;
			2'h2: p = 4'ha;
			default: p = 4'h8;
		endcase
		case (c[2:0])
			3'h1: d = 4'ha;
			3'h2: d = 4'hb;
			3'h3: d = 4'hc;
			3'h4: d = 4'h8;
			3'h5: d = 4'h7;
			3'h6: d = 4'h6;
			default: d = 4'h9;
		endcase
		return {p, d};
	endfunction
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	initial begin
		#20000;
		err_total++;
		close_out;
	end
	initial begin
		repeat (5) @(posedge clk_in);
		#1 srst_in = 1'b0;
		for (i = 0; i < 5; i++) r(i[7:0], 8'h00);
		chk({pct, dlg}, 8'hc9);
		chk({3'h0, cua}, 8'h10);
		// signed margins, buck then boost
		w(8'h01, 8'hc5, 1'b1, 2'b10);
		w(8'h02, 8'h3a, 1'b1, 2'b10);
		tick(2);
		chk({lsink, lua}, 8'hc5);
		chk({hsink, hua}, 8'h00);
		r(8'h01, 8'h45);
		buck_mode_in = 1'b0;
		tick(5);
		chk({1'b0, lua}, 8'h00);
		chk({hsink, hua}, 8'h3a);
		foreach (cs[j]) begin
			w(8'h03, cs[j], 1'b1, 2'b10);
			tick(2);
			chk({3'h0, cua}, cx[j]);
			r(8'h03, cs[j] & 8'h1f);
		end
		for (i = 0; i < 32; i++) begin
			w(8'h04, 8'he0 | i[7:0], 1'b1, 2'b10);
			tick(2);
			chk({pct, dlg}, spexp(i[4:0]));
			r(8'h04, i[7:0]);
		end
		w(8'h05, 8'h5a, 1'b1, 2'b01);
		r(8'h05, 8'h00);
		// write protect over the four dac and spread registers, chip control stays writable
		w(8'h00, 8'hf1, 1'b1, 2'b10);
		r(8'h00, 8'h01);
		chk({7'h00, wpo}, 8'h01);
		for (i = 1; i < 5; i++) w(i[7:0], 8'h0b, 1'b1, 2'b01);
		r(8'h02, 8'h3a);
		w(8'h00, 8'h00, 1'b1, 2'b10);
		w(8'h02, 8'h2b, 1'b1, 2'b10);
		// failed check, then clearing
		w(8'h02, 8'h11, 1'b0, 2'b01);
		r(8'h02, 8'h2b);
		r(8'h00, 8'h04);
		chk({7'h00, fault}, 8'h01);
		w(8'h00, 8'h00, 1'b1, 2'b10);
		r(8'h00, 8'h04);
		w(8'h00, 8'h04, 1'b1, 2'b10);
		r(8'h00, 8'h00);
		// soft reset with protect set in the same write
		w(8'h00, 8'h03, 1'b1, 2'b10);
		for (i = 0; i < 5; i++) r(i[7:0], 8'h00);
		chk({3'h0, cua}, 8'h10);
		close_out;
	end
endmodule
